/* logic/msr_consts.svh */
/*
 * timing counts, sizes and clock rates of the multi-converter readout.
 * assumes a 250 MHz core clock and converters that halve their reference clock.
 */
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// =====================================================================
// sizes
`define MSR_NCONV 4
`define MSR_WORD_BITS 24
`define MSR_FRAME_WORDS 5
`define MSR_MEM_WORDS 20
`define MSR_ADDR_BITS 5

// =====================================================================
// clock rates
`define MSR_CLK_KHZ 250000
`define MSR_REF_KHZ 8192
`define MSR_XTAL_KHZ 16384
`define MSR_SCLK_MAX_KHZ 19968
`define MSR_CONV_MOD_DIV 2
`define MSR_SAMPLE_RATE_HZ 4000

// =====================================================================
// derived cycle counts
`define MSR_SCLK_HALF ((`MSR_CLK_KHZ + 2 * `MSR_SCLK_MAX_KHZ - 1) / (2 * `MSR_SCLK_MAX_KHZ))
`define MSR_PWM_HALF (`MSR_CLK_KHZ / (2 * `MSR_REF_KHZ))
`define MSR_CS_GAP_NS 40
`define MSR_CS_GAP_CYC ((`MSR_CS_GAP_NS * `MSR_CLK_KHZ + 999999) / 1000000)
`define MSR_PULSE_NS 1000
`define MSR_PULSE_CYC ((`MSR_PULSE_NS * `MSR_CLK_KHZ + 999999) / 1000000)
`define MSR_OSC_TIMEOUT_CYC (4 * `MSR_CLK_KHZ / `MSR_XTAL_KHZ)

`endif

/* logic/msr_pkg.sv */
/*
 * types of the multi-converter readout: modes, states and carriers.
 * assumes msr_consts.svh sits on the include path.
 */
`include "msr_consts.svh"

package msr_pkg;

    // =====================================================================
    // reference clock source
    typedef enum logic [1:0] {
        MSR_REF_EXT = 2'h0,
        MSR_REF_XTAL = 2'h1,
        MSR_REF_PWM = 2'h2
    } msr_ref_mode_t;

    // =====================================================================
    // readout sequencer
    typedef enum logic [3:0] {
        MSR_S_IDLE = 4'h1,
        MSR_S_SETUP = 4'h2,
        MSR_S_SHIFT = 4'h4,
        MSR_S_GAP = 4'h8
    } msr_state_t;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [1:0] conv;
        logic [2:0] word;
        logic [`MSR_WORD_BITS-1:0] data;
    } msr_sample_t;

    typedef struct packed {
        logic reactive;
        logic active;
    } msr_pulse_req_t;

endpackage : msr_pkg

/* logic/msr_sample_mem.sv */
/*
 * sample set buffer: one write port, one read port with registered data.
 * assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "msr_consts.svh"

module msr_sample_mem (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [`MSR_ADDR_BITS-1:0] wr_addr,
    input wire logic [`MSR_WORD_BITS-1:0] wr_data,
    input wire logic [`MSR_ADDR_BITS-1:0] rd_addr,
    output logic [`MSR_WORD_BITS-1:0] rd_data
);
    import msr_pkg::*;

    logic [`MSR_WORD_BITS-1:0] mem [`MSR_MEM_WORDS];
    logic [`MSR_WORD_BITS-1:0] rd_data_next;

    always_comb
    begin
        rd_data_next = '0;
        if (rd_addr < `MSR_ADDR_BITS'(`MSR_MEM_WORDS))
        begin
            rd_data_next = mem[rd_addr];
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_en && wr_addr < `MSR_ADDR_BITS'(`MSR_MEM_WORDS))
        begin
            mem[wr_addr] <= wr_data;
        end
        if (srst)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= rd_data_next;
        end
    end

endmodule : msr_sample_mem

/* logic/msr_readout.sv */
/*
 * host side acquisition for four delta-sigma converters on one serial bus:
 * reference clock source, data-ready capture, sequential readout, energy pulses.
 * assumes external buffers fan clocks out; pins arrive asynchronous to CLK.
 */
//
// Overview of operation
// RL1 - each converter halves its reference clock to make its modulator clock
// RL2 - default 8.192 MHz reference feeds converters and host; host output stays idle
// RL3 - without that reference, host halves a 16.384 MHz crystal onto its clock output
// RL4 - optional evaluation PWM clock, only while the crystal input is alive
// RL5 - host drives one serial clock, copied in phase to all four converters
// RL6 - one chip select per converter, generated and sequenced by this block
// RL7 - converters pull their data-ready low together when new samples exist
// RL8 - on data-ready falling edge, read every converter and move words to buffer
// RL9 - finish one converter before the next; never two at once
// RL10 - drive active and reactive energy pulse outputs
// RL11 - mains-locked reference trimming is not provided here
// RL12 - converters deliver 4000 sample sets per second; readout must keep up
// RL13 - hold each select for one whole frame, release, then next in fixed order
`timescale 1ns/1ps
`include "msr_consts.svh"

module msr_readout (
    input wire logic CLK,
    input wire logic SRST,
    input wire msr_pkg::msr_ref_mode_t REF_MODE,
    input wire logic HOST_OSC_IN,
    output logic HOST_REF_CLOCK_OUT,
    output logic OSC_PRESENT,
    input wire logic [3:0] SAMPLE_READY_N,
    output logic [3:0] SCLK_OUT,
    output logic [3:0] CS_N,
    input wire logic MISO,
    input wire logic [`MSR_ADDR_BITS-1:0] RD_ADDR,
    output logic [`MSR_WORD_BITS-1:0] RD_DATA,
    output logic WORD_VALID,
    output msr_pkg::msr_sample_t WORD_OUT,
    output logic SET_DONE,
    output logic OVERRUN,
    input wire msr_pkg::msr_pulse_req_t ENERGY_REQ,
    output logic ACTIVE_ENERGY_PULSE,
    output logic REACTIVE_ENERGY_PULSE
);
    import msr_pkg::*;

    // =====================================================================
    // input synchronisers
    logic [5:0] sync1_reg, sync2_reg;
    logic sample_ready_n_low_reg, sample_ready_n_low_next;
    logic sample_ready_n_fall, osc_s, miso_s;

    assign osc_s = sync2_reg[5];
    assign miso_s = sync2_reg[4];
    assign sample_ready_n_low_next = ~|sync2_reg[3:0];
    assign sample_ready_n_fall = sample_ready_n_low_next && !sample_ready_n_low_reg; // [RL7] [RL8]

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sync1_reg <= 6'h3F;
            sync2_reg <= 6'h3F;
            sample_ready_n_low_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {HOST_OSC_IN, MISO, SAMPLE_READY_N};
            sync2_reg <= sync1_reg;
            sample_ready_n_low_reg <= sample_ready_n_low_next;
        end
    end

    // =====================================================================
    // reference clock source
    logic osc_prev_reg, osc_prev_next, osc_div_reg, osc_div_next;
    logic [5:0] osc_idle_reg, osc_idle_next;
    logic [4:0] pwm_cnt_reg, pwm_cnt_next;
    logic pwm_reg, pwm_next, ref_out_reg, ref_out_next;
    logic osc_rise, osc_ok;

    assign osc_rise = osc_s && !osc_prev_reg;
    assign osc_ok = osc_idle_reg < 6'(`MSR_OSC_TIMEOUT_CYC);

    always_comb
    begin
        osc_prev_next = osc_s;
        osc_div_next = osc_rise ? !osc_div_reg : osc_div_reg; // [RL3]
        osc_idle_next = osc_rise ? 6'h00 : (osc_ok ? osc_idle_reg + 6'h01 : osc_idle_reg);
        pwm_cnt_next = pwm_cnt_reg + 5'h01;
        pwm_next = pwm_reg;
        if (pwm_cnt_reg == 5'(`MSR_PWM_HALF - 1))
        begin
            pwm_cnt_next = 5'h00;
            pwm_next = !pwm_reg;
        end
        // mains-locked trimming absent: reference fixed per mode [RL11]
        unique case (REF_MODE)
            MSR_REF_XTAL: ref_out_next = osc_div_reg; // [RL3]
            MSR_REF_PWM: ref_out_next = osc_ok && pwm_reg; // [RL4]
            default: ref_out_next = 1'b0; // [RL2]
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            osc_prev_reg <= 1'b1;
            osc_div_reg <= 1'b0;
            osc_idle_reg <= 6'(`MSR_OSC_TIMEOUT_CYC);
            pwm_cnt_reg <= 5'h00;
            pwm_reg <= 1'b0;
            ref_out_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= osc_prev_next;
            osc_div_reg <= osc_div_next;
            osc_idle_reg <= osc_idle_next;
            pwm_cnt_reg <= pwm_cnt_next;
            pwm_reg <= pwm_next;
            ref_out_reg <= ref_out_next;
        end
    end

    assign HOST_REF_CLOCK_OUT = ref_out_reg;
    assign OSC_PRESENT = osc_ok;

    // =====================================================================
    // readout sequencer
    msr_state_t state_reg, state_next;
    logic [1:0] conv_reg, conv_next;
    logic [2:0] word_reg, word_next;
    logic [4:0] bit_reg, bit_next;
    logic [3:0] div_reg, div_next;
    logic sclk_reg, sclk_next;
    logic [3:0] cs_n_reg, cs_n_next;
    logic [`MSR_WORD_BITS-1:0] shift_reg, shift_next;
    logic we_reg, we_next, done_reg, done_next, ovr_reg, ovr_next;
    msr_sample_t wout_reg, wout_next;
    logic [`MSR_ADDR_BITS-1:0] waddr;

    assign waddr = {3'h0, wout_reg.conv} * 5'(`MSR_FRAME_WORDS) + {2'h0, wout_reg.word};

    always_comb
    begin
        state_next = state_reg;
        conv_next = conv_reg;
        word_next = word_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        sclk_next = sclk_reg;
        cs_n_next = cs_n_reg;
        shift_next = shift_reg;
        we_next = 1'b0;
        done_next = 1'b0;
        ovr_next = sample_ready_n_fall && state_reg != MSR_S_IDLE; // [RL12]
        wout_next = wout_reg;
        unique case (state_reg)
            MSR_S_IDLE:
            begin
                if (sample_ready_n_fall) // [RL8]
                begin
                    conv_next = 2'h0;
                    cs_n_next = 4'hE; // [RL6]
                    div_next = 4'h0;
                    state_next = MSR_S_SETUP;
                end
            end
            MSR_S_SETUP:
            begin
                div_next = div_reg + 4'h1;
                if (div_reg == 4'(`MSR_SCLK_HALF - 1))
                begin
                    div_next = 4'h0;
                    word_next = 3'h0;
                    bit_next = 5'h00;
                    state_next = MSR_S_SHIFT;
                end
            end
            MSR_S_SHIFT:
            begin
                div_next = div_reg + 4'h1;
                if (div_reg == 4'(`MSR_SCLK_HALF - 1))
                begin
                    div_next = 4'h0;
                    sclk_next = !sclk_reg; // [RL5]
                    if (sclk_reg)
                    begin
                        shift_next = {shift_reg[`MSR_WORD_BITS-2:0], miso_s};
                        bit_next = bit_reg + 5'h01;
                        if (bit_reg == 5'(`MSR_WORD_BITS - 1))
                        begin
                            bit_next = 5'h00;
                            we_next = 1'b1; // [RL8]
                            wout_next = '{conv: conv_reg, word: word_reg, data: shift_next};
                            word_next = word_reg + 3'h1;
                            if (word_reg == 3'(`MSR_FRAME_WORDS - 1))
                            begin
                                cs_n_next = 4'hF; // [RL13]
                                state_next = MSR_S_GAP;
                            end
                        end
                    end
                end
            end
            MSR_S_GAP:
            begin
                div_next = div_reg + 4'h1;
                if (div_reg == 4'(`MSR_CS_GAP_CYC - 1))
                begin
                    div_next = 4'h0;
                    if (conv_reg == 2'(`MSR_NCONV - 1))
                    begin
                        done_next = 1'b1;
                        state_next = MSR_S_IDLE;
                    end
                    else
                    begin
                        conv_next = conv_reg + 2'h1; // [RL9] [RL13]
                        cs_n_next = ~(4'h1 << (conv_reg + 2'h1)); // [RL6]
                        state_next = MSR_S_SETUP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_reg <= MSR_S_IDLE;
            conv_reg <= 2'h0;
            word_reg <= 3'h0;
            bit_reg <= 5'h00;
            div_reg <= 4'h0;
            sclk_reg <= 1'b0;
            cs_n_reg <= 4'hF;
            shift_reg <= '0;
            we_reg <= 1'b0;
            done_reg <= 1'b0;
            ovr_reg <= 1'b0;
            wout_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            conv_reg <= conv_next;
            word_reg <= word_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            cs_n_reg <= cs_n_next;
            shift_reg <= shift_next;
            we_reg <= we_next;
            done_reg <= done_next;
            ovr_reg <= ovr_next;
            wout_reg <= wout_next;
        end
    end

    assign SCLK_OUT = {4{sclk_reg}}; // [RL5]
    assign CS_N = cs_n_reg;
    assign WORD_VALID = we_reg;
    assign WORD_OUT = wout_reg;
    assign SET_DONE = done_reg;
    assign OVERRUN = ovr_reg;

    msr_sample_mem u_mem (
        .clk(CLK),
        .srst(SRST),
        .wr_en(we_reg),
        .wr_addr(waddr),
        .wr_data(wout_reg.data),
        .rd_addr(RD_ADDR),
        .rd_data(RD_DATA)
    );

    // =====================================================================
    // energy pulse outputs
    logic [1:0] req_vec, pulse_reg, pulse_next;
    logic [7:0] pcnt_reg [2];
    logic [7:0] pcnt_next [2];

    assign req_vec = {ENERGY_REQ.reactive, ENERGY_REQ.active};

    for (genvar i = 0; i < 2; i++)
    begin : g_pulse
        always_comb
        begin
            pcnt_next[i] = pcnt_reg[i];
            if (pcnt_reg[i] != 8'h00)
            begin
                pcnt_next[i] = pcnt_reg[i] - 8'h01;
            end
            else if (req_vec[i])
            begin
                pcnt_next[i] = 8'(`MSR_PULSE_CYC); // [RL10]
            end
            pulse_next[i] = pcnt_next[i] != 8'h00;
        end

        always_ff @(posedge CLK)
        begin
            if (SRST)
            begin
                pcnt_reg[i] <= 8'h00;
                pulse_reg[i] <= 1'b0;
            end
            else
            begin
                pcnt_reg[i] <= pcnt_next[i];
                pulse_reg[i] <= pulse_next[i];
            end
        end
    end

    assign ACTIVE_ENERGY_PULSE = pulse_reg[0];
    assign REACTIVE_ENERGY_PULSE = pulse_reg[1];

    // =====================================================================
    // checks
    a_cs_one_only: assert property (@(posedge CLK) disable iff (SRST) // [RL9]
        $onehot0(~cs_n_reg)) else $error("two converters selected");
    a_cs_next_order: assert property (@(posedge CLK) disable iff (SRST) // [RL13]
        (state_reg == MSR_S_SETUP && $past(state_reg) == MSR_S_GAP)
        |-> conv_reg == $past(conv_reg) + 2'h1 && cs_n_reg == ~(4'h1 << conv_reg))
        else $error("select order broken");
    a_sclk_idle_low: assert property (@(posedge CLK) disable iff (SRST) // [RL5]
        (&cs_n_reg) |-> !sclk_reg) else $error("serial clock runs unselected");
    a_sample_ready_n_start: assert property (@(posedge CLK) disable iff (SRST) // [RL8]
        (sample_ready_n_fall && state_reg == MSR_S_IDLE) |=> state_reg == MSR_S_SETUP && cs_n_reg == 4'hE)
        else $error("data-ready edge not served");
    a_done_last: assert property (@(posedge CLK) disable iff (SRST) // [RL9]
        done_reg |-> state_reg == MSR_S_IDLE && conv_reg == 2'h3 && $past(state_reg) == MSR_S_GAP)
        else $error("set done too early");
    a_xtal_halves: assert property (@(posedge CLK) disable iff (SRST) // [RL3]
        (REF_MODE == MSR_REF_XTAL && osc_rise) ##1 (REF_MODE == MSR_REF_XTAL)
        |-> osc_div_reg != $past(osc_div_reg) ##1 ref_out_reg == $past(osc_div_reg))
        else $error("crystal not halved");
    a_ext_quiet: assert property (@(posedge CLK) disable iff (SRST) // [RL2]
        (REF_MODE == MSR_REF_EXT) |=> !ref_out_reg) else $error("clock out active on ext ref");
    a_pwm_needs_osc: assert property (@(posedge CLK) disable iff (SRST) // [RL4]
        (REF_MODE == MSR_REF_PWM && !osc_ok) |=> !ref_out_reg) else $error("pwm without osc");
    a_pulse_width: assert property (@(posedge CLK) disable iff (SRST) // [RL10]
        $rose(pulse_reg[0]) |-> pcnt_reg[0] == 8'(`MSR_PULSE_CYC) ##1 pulse_reg[0] [*8])
        else $error("energy pulse too short");

endmodule : msr_readout

/* dv/msr_conv_model.sv */
/*
 * behavioural model of four converters on the shared serial bus.
 * assumes the host drives sclk and cs_n from registers on clk.
 */
`timescale 1ns/1ps

module msr_conv_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [3:0] sclk,
    input wire logic [3:0] cs_n,
    output logic [3:0] ready_n,
    output logic miso,
    input wire logic ref_clk,
    output logic mod_clk
);
    import msr_pkg::*;

    // =====================================================================
    // state
    logic sclk_q = 1'b0;
    logic ref_q = 1'b0;
    logic [6:0] bit_cnt = 7'h00;
    logic [7:0] hold_cnt = 8'h00;
    logic [1:0] conv;
    logic [23:0] word;

    initial
    begin
        ready_n = 4'hF;
        miso = 1'b0;
        mod_clk = 1'b0;
    end

    // =====================================================================
    // selected converter and its current word
    assign conv = !cs_n[0] ? 2'h0 : !cs_n[1] ? 2'h1 : !cs_n[2] ? 2'h2 : 2'h3;
    assign word = {4'hA, 2'h0, conv, 4'(bit_cnt / 24), 12'h5C3};

    always @(posedge clk)
    begin
        sclk_q <= sclk[conv];
        // modulator clock at half the reference rate
        ref_q <= ref_clk;
        if (ref_clk && !ref_q)
            mod_clk <= ~mod_clk;
        // all four ready outputs fall together
        if (fire)
        begin
            ready_n <= 4'h0;
            hold_cnt <= 8'h32;
        end
        else if (hold_cnt != 8'h00)
            hold_cnt <= hold_cnt - 8'h01;
        else
            ready_n <= 4'hF;
        // released line toggles, selected one shifts msb first on rising
        if (&cs_n)
        begin
            bit_cnt <= 7'h00;
            miso <= ~miso;
        end
        else if (sclk[conv] && !sclk_q)
        begin
            miso <= word[5'd23 - 5'(bit_cnt % 24)];
            bit_cnt <= bit_cnt + 7'h01;
        end
    end
endmodule : msr_conv_model

/* dv/testbench.sv */
/*
 * self-checking bench of the multi-converter readout.
 * assumes msr_pkg and the design are compiled first.
 */
`timescale 1ns/1ps
`include "msr_consts.svh"

module testbench;
    import msr_pkg::*;

    // =====================================================================
    // signals
    logic clk = 1'b0, srst = 1'b1, fire = 1'b0, osc = 1'b0, osc_run = 1'b0, mon_en = 1'b0;
    msr_ref_mode_t ref_mode = MSR_REF_EXT;
    msr_pulse_req_t energy_req = '0;
    logic [4:0] rd_addr = 5'h00;
    logic [3:0] ready_n, sclk, cs_n, cs_q;
    logic miso, ref_out, osc_present, word_valid, set_done, overrun, act, reactive_energy_pulse, sclk_q;
    logic mod_clk, mod_q = 1'b0;
    logic [23:0] rd_data;
    msr_sample_t word_out;
    int err_total = 0, cmp_count = 0, cyc = 0, osc_cnt = 0, rises = 0, mod_rises = 0;
    int sel_q[$], rise_q[$];

    msr_readout dut_u (.CLK(clk), .SRST(srst), .REF_MODE(ref_mode), .HOST_OSC_IN(osc),
        .HOST_REF_CLOCK_OUT(ref_out), .OSC_PRESENT(osc_present), .SAMPLE_READY_N(ready_n),
        .SCLK_OUT(sclk), .CS_N(cs_n), .MISO(miso), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .WORD_VALID(word_valid), .WORD_OUT(word_out), .SET_DONE(set_done),
        .OVERRUN(overrun), .ENERGY_REQ(energy_req), .ACTIVE_ENERGY_PULSE(act),
        .REACTIVE_ENERGY_PULSE(reactive_energy_pulse));

    msr_conv_model conv_u (.clk(clk), .fire(fire), .sclk(sclk), .cs_n(cs_n),
        .ready_n(ready_n), .miso(miso), .ref_clk(ref_out), .mod_clk(mod_clk));

    initial
    begin
        forever #2 clk = ~clk;
    end

    // =====================================================================
    // helpers
    task automatic print_verdict;
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [23:0] exp_word(input int c, input int w);
        return {4'hA, 2'h0, 2'(c), 4'(w), 12'h5C3};
    endfunction : exp_word

    task automatic count_rises(input int n, output int nr, output int no);
        logic r, o;
        nr = 0;
        no = 0;
        r = ref_out;
        o = osc;
        repeat (n)
        begin
            @(posedge clk);
            nr += (ref_out && !r);
            no += (osc && !o);
            r = ref_out;
            o = osc;
        end
    endtask : count_rises

    // =====================================================================
    // crystal stand-in, bus monitor, timeout
    always @(posedge clk)
    begin
        if (osc_run)
            osc_cnt <= (osc_cnt == 7) ? 0 : osc_cnt + 1;
        if (osc_run && osc_cnt == 7)
            osc <= ~osc;
        cyc <= cyc + 1;
        mod_q <= mod_clk;
        if (mod_clk && !mod_q)
            mod_rises <= mod_rises + 1;
        if (cyc == 40000)
        begin
            err_total++;
            print_verdict();
        end
    end

    always @(posedge clk)
    begin
        cs_q <= cs_n;
        sclk_q <= sclk[0];
        if (mon_en)
        begin
            check($countones(~cs_n) <= 1, 1);
            check(sclk == {4{sclk[0]}}, 1);
            if (&cs_n)
                check(sclk, 4'h0);
            for (int k = 0; k < 4; k++)
                if (cs_q[k] && !cs_n[k])
                    sel_q.push_back(k);
            if (cs_n != cs_q)
                rises <= 0;
            else if (sclk[0] && !sclk_q)
                rises <= rises + 1;
            if (!(&cs_q) && (&cs_n))
                rise_q.push_back(rises);
        end
    end

    // =====================================================================
    // scenarios
    task automatic t_reset;
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(cs_n, 4'hF);
        check({sclk, ref_out, act, reactive_energy_pulse, osc_present}, 8'h00);
        check({word_valid, set_done, overrun}, 3'h0);
    endtask : t_reset

    task automatic t_readout;
        int n, c, budget;
        msr_sample_t s;
        sel_q.delete();
        rise_q.delete();
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        n = 0;
        c = 0;
        while (set_done !== 1'b1 && c < 8000)
        begin
            @(posedge clk);
            c++;
            if (word_valid === 1'b1)
            begin
                s = word_out;
                check(s.conv, n / 5);
                check(s.word, n % 5);
                check(s.data, exp_word(n / 5, n % 5));
                n++;
            end
        end
        check(n, 20);
        budget = `MSR_SCLK_HALF * (2 * `MSR_WORD_BITS * `MSR_FRAME_WORDS + 1) + `MSR_CS_GAP_CYC;
        check(c, `MSR_NCONV * budget + 4);
        check(sel_q.size(), 4);
        foreach (sel_q[k])
            check(sel_q[k], k);
        foreach (rise_q[k])
            check(rise_q[k], 120);
        for (int a = 0; a <= 20; a++)
        begin
            rd_addr <= 5'(a);
            @(posedge clk);
            @(posedge clk);
            check(rd_data, a < 20 ? exp_word(a / 5, a % 5) : 24'h000000);
        end
    endtask : t_readout

    task automatic t_overrun;
        int seen;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (200) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        seen = 0;
        repeat (10)
        begin
            @(posedge clk);
            seen += (overrun === 1'b1);
        end
        check(seen, 1);
        repeat (8000)
        begin
            @(posedge clk);
            if (set_done === 1'b1)
                break;
        end
        seen = 0;
        repeat (100)
        begin
            @(posedge clk);
            seen += (cs_n !== 4'hF);
        end
        check(seen, 0);
    endtask : t_overrun

    task automatic t_energy;
        int na, nr;
        for (int i = 0; i < 2; i++)
        begin
            energy_req <= msr_pulse_req_t'(2'(1 << i));
            @(posedge clk);
            energy_req <= '0;
            na = 0;
            nr = 0;
            repeat (400)
            begin
                @(posedge clk);
                na += (act === 1'b1);
                nr += (reactive_energy_pulse === 1'b1);
            end
            check(na, i == 0 ? 250 : 0);
            check(nr, i == 1 ? 250 : 0);
        end
    endtask : t_energy

    task automatic t_refclk;
        int nr, no, m0;
        osc_run <= 1'b1;
        ref_mode <= MSR_REF_EXT;
        count_rises(300, nr, no);
        check(nr, 0);
        ref_mode <= MSR_REF_XTAL;
        repeat (10) @(posedge clk);
        m0 = mod_rises;
        count_rises(320, nr, no);
        check(osc_present, 1'b1);
        check(mod_rises - m0 >= nr / 2 - 1 && mod_rises - m0 <= nr / 2 + 1, 1);
        check(nr >= no / 2 - 1 && nr <= no / 2 + 1, 1);
        ref_mode <= MSR_REF_PWM;
        repeat (40) @(posedge clk);
        count_rises(300, nr, no);
        check(nr >= 9 && nr <= 11, 1);
        osc_run <= 1'b0;
        repeat (100) @(posedge clk);
        check(osc_present, 1'b0);
        count_rises(100, nr, no);
        check(nr, 0);
    endtask : t_refclk

    // =====================================================================
    // main sequence
    initial
    begin
        t_reset();
        mon_en <= 1'b1;
        t_readout();
        t_overrun();
        mon_en <= 1'b0;
        t_reset();
        t_energy();
        t_refclk();
        print_verdict();
    end
endmodule : testbench
